/* File: logic/ssr_err_queue.sv */
// error queue memory: first in, first out, head word registered
`timescale 1ns/1ns
module ssr_err_queue #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // queue port
  ssr_q_if.mem q
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("ssr_err_queue: DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic [WIDTH-1:0] head_q, head_d;
  logic do_push, do_pop;

  always_comb begin
    do_pop = q.pop && (cnt_q != '0);
    do_push = q.push && ((cnt_q != CW'(DEPTH)) || do_pop);
    wp_d = do_push ? wp_q + 1'b1 : wp_q;
    rp_d = do_pop ? rp_q + 1'b1 : rp_q;
    cnt_d = cnt_q + CW'(do_push) - CW'(do_pop);
    // head is the word at the new read pointer, or the incoming word when it lands there
    if (do_push && (cnt_d == CW'(1))) begin
      head_d = q.wdata;
    end else if (do_pop && (cnt_q > CW'(1))) begin
      head_d = mem_q[rp_d];
    end else begin
      head_d = head_q;
    end
  end

  always_ff @(posedge pclk) begin
    if (do_push) begin
      mem_q[wp_q] <= q.wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      head_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
      head_q <= head_d;
    end
  end

  assign q.rdata = head_q;
  assign q.empty = (cnt_q == '0);
  assign q.full = (cnt_q == CW'(DEPTH));
  assign q.count = cnt_q;
endmodule : ssr_err_queue

/* File: logic/ssr_map.svh */
// register offsets, reset values and field positions of the status reporting block
`ifndef SSR_MAP_SVH
`define SSR_MAP_SVH
`define SSR_W 15
`define SSR_OFF_OPER_COND 12'h000
`define SSR_OFF_OPER_EVT 12'h004
`define SSR_OFF_OPER_EN 12'h008
`define SSR_OFF_OPER_PTR 12'h00c
`define SSR_OFF_OPER_NTR 12'h010
`define SSR_OFF_QUES_COND 12'h014
`define SSR_OFF_QUES_EVT 12'h018
`define SSR_OFF_QUES_EN 12'h01c
`define SSR_OFF_QUES_PTR 12'h020
`define SSR_OFF_QUES_NTR 12'h024
`define SSR_OFF_PRESET 12'h028
`define SSR_OFF_ERR_NEXT 12'h02c
`define SSR_OFF_ERR_COUNT 12'h030
`define SSR_OFF_IRQ_STAT 12'h034
`define SSR_OFF_IRQ_MASK 12'h038
`define SSR_OFF_ERR_PUSH 12'h03c
`define SSR_PTR_PRESET 15'h7fff
`define SSR_NTR_PRESET 15'h0000
`define SSR_EN_PRESET 15'h0000
`define SSR_PTR_RESET 15'h7fff
`define SSR_NTR_RESET 15'h0000
`define SSR_EN_RESET 15'h0000
`define SSR_COND_RESET 15'h0000
`define SSR_EVT_RESET 15'h0000
`define SSR_NO_ERROR 16'h0000
`define SSR_IRQ_OPER_BIT 0
`define SSR_IRQ_QUES_BIT 1
`define SSR_IRQ_ERR_BIT 2
`define SSR_IRQ_OVF_BIT 3
`define SSR_IRQ_W 4
`endif

/* File: logic/ssr_pkg.sv */
// types of the status reporting block
package ssr_pkg;
  typedef logic [14:0] ssr_word_t;
  typedef logic signed [15:0] ssr_err_t;
endpackage : ssr_pkg

/* File: logic/ssr_q_if.sv */
// error queue carrier between the register bank and its queue memory
`timescale 1ns/1ns
interface ssr_q_if #(parameter int WIDTH = 16, parameter int DEPTH = 8);
  logic push;
  logic pop;
  logic [WIDTH-1:0] wdata;
  logic [WIDTH-1:0] rdata;
  logic empty;
  logic full;
  logic [$clog2(DEPTH+1)-1:0] count;
  modport bank (output push, output pop, output wdata, input rdata, input empty, input full, input count);
  modport mem (input push, input pop, input wdata, output rdata, output empty, output full, output count);
endinterface : ssr_q_if

/* File: logic/ssr_status_regs.sv */
// status reporting register bank: operation and questionable groups, error queue, apb slave
//
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`include "ssr_map.svh"

module ssr_status_regs
  import ssr_pkg::*;
#(
  parameter int ERR_DEPTH = 8
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // live hardware state
  input wire logic [14:0] oper_cond_in,
  input wire logic [14:0] ques_cond_in,
  // error reporting from the instrument
  input wire logic err_push,
  input wire logic [15:0] err_code,
  // instrument reset command, has no effect here
  input wire logic inst_reset,
  // summaries and interrupt
  output logic oper_summary,
  output logic ques_summary,
  output logic srq,
  output logic irq
);
  // ----------------------------------------
  // parameter checks
  // ----------------------------------------
  localparam int CNT_W = $clog2(ERR_DEPTH + 1);
  // queue pointers wrap by overflow, so only powers of two are served
  if (ERR_DEPTH < 2 || (ERR_DEPTH & (ERR_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("ssr_status_regs: ERR_DEPTH must be a power of two, at least 2");
  end
  // the entry count must fit the read data word
  if (CNT_W > 32) begin : g_bad_count
    $error("ssr_status_regs: ERR_DEPTH too large for the count register");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  ssr_word_t cond_q [2], cond_d [2];
  ssr_word_t evt_q [2], evt_d [2];
  ssr_word_t en_q [2], en_d [2];
  ssr_word_t ptr_q [2], ptr_d [2];
  ssr_word_t ntr_q [2], ntr_d [2];
  logic [1:0] sum_q, sum_d;
  logic srq_q, srq_d;
  logic [`SSR_IRQ_W-1:0] ist_q, ist_d, imask_q, imask_d;
  logic irq_q, irq_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;

  ssr_q_if #(.WIDTH(16), .DEPTH(ERR_DEPTH)) errq ();

  ssr_err_queue #(.WIDTH(16), .DEPTH(ERR_DEPTH)) i_ssr_err_queue (
    .pclk(pclk),
    .presetn(presetn),
    .q(errq.bank)
  );

  // ----------------------------------------
  // apb decode
  // ----------------------------------------
  logic acc, wr, rd, hit, preset_cmd;
  logic [1:0] rd_evt;
  logic [1:0] wr_en_sel, wr_ptr_sel, wr_ntr_sel;
  logic wr_istat, wr_imask, wr_push, rd_next;
  logic [1:0] new_evt;
  ssr_word_t wval;
  ssr_word_t raw_in [2];

  assign raw_in[0] = oper_cond_in;
  assign raw_in[1] = ques_cond_in;
  // one wait state: the access phase is answered on its second cycle
  assign acc = psel && penable && !pready_q;
  assign wr = acc && pwrite;
  assign rd = acc && !pwrite;
  assign wval = pwdata[14:0];

  always_comb begin
    hit = 1'b1;
    prdata_d = 32'h0000_0000;
    preset_cmd = 1'b0;
    rd_evt = 2'b00;
    wr_en_sel = 2'b00;
    wr_ptr_sel = 2'b00;
    wr_ntr_sel = 2'b00;
    wr_istat = 1'b0;
    wr_imask = 1'b0;
    wr_push = 1'b0;
    rd_next = 1'b0;
    if (paddr == `SSR_OFF_OPER_COND) begin
      prdata_d = {17'h0, cond_q[0]};
    end else if (paddr == `SSR_OFF_OPER_EVT) begin
      prdata_d = {17'h0, evt_q[0]};
      rd_evt[0] = rd;
    end else if (paddr == `SSR_OFF_OPER_EN) begin
      prdata_d = {17'h0, en_q[0]};
      wr_en_sel[0] = wr;
    end else if (paddr == `SSR_OFF_OPER_PTR) begin
      prdata_d = {17'h0, ptr_q[0]};
      wr_ptr_sel[0] = wr;
    end else if (paddr == `SSR_OFF_OPER_NTR) begin
      prdata_d = {17'h0, ntr_q[0]};
      wr_ntr_sel[0] = wr;
    end else if (paddr == `SSR_OFF_QUES_COND) begin
      prdata_d = {17'h0, cond_q[1]};
    end else if (paddr == `SSR_OFF_QUES_EVT) begin
      prdata_d = {17'h0, evt_q[1]};
      rd_evt[1] = rd;
    end else if (paddr == `SSR_OFF_QUES_EN) begin
      prdata_d = {17'h0, en_q[1]};
      wr_en_sel[1] = wr;
    end else if (paddr == `SSR_OFF_QUES_PTR) begin
      prdata_d = {17'h0, ptr_q[1]};
      wr_ptr_sel[1] = wr;
    end else if (paddr == `SSR_OFF_QUES_NTR) begin
      prdata_d = {17'h0, ntr_q[1]};
      wr_ntr_sel[1] = wr;
    end else if (paddr == `SSR_OFF_PRESET) begin
      preset_cmd = wr;
    end else if (paddr == `SSR_OFF_ERR_NEXT) begin
      // sign-extended so software sees the code's sign directly
      prdata_d = errq.empty ? {{16{1'b0}}, `SSR_NO_ERROR}
                            : {{16{errq.rdata[15]}}, errq.rdata};
      rd_next = rd;
    end else if (paddr == `SSR_OFF_ERR_COUNT) begin
      prdata_d = 32'(errq.count);
    end else if (paddr == `SSR_OFF_IRQ_STAT) begin
      prdata_d = {28'h0, ist_q};
      wr_istat = wr;
    end else if (paddr == `SSR_OFF_IRQ_MASK) begin
      prdata_d = {28'h0, imask_q};
      wr_imask = wr;
    end else if (paddr == `SSR_OFF_ERR_PUSH) begin
      prdata_d = 32'h0000_0000;
      wr_push = wr;
    end else begin
      hit = 1'b0;
    end
    if (!rd) begin
      prdata_d = prdata_q;
    end
    pready_d = acc;
    pslverr_d = acc && !hit;
  end

  // ----------------------------------------
  // error queue
  // ----------------------------------------
  // popped by a read of the next-entry register, fed by hardware or software
  assign errq.pop = rd_next;
  assign errq.push = err_push || wr_push;
  // hardware outranks software in one cycle; the software word is then lost
  assign errq.wdata = err_push ? err_code : pwdata[15:0];

  // ----------------------------------------
  // status groups
  // ----------------------------------------
  // inst_reset deliberately reaches nothing below
  for (genvar g = 0; g < 2; g++) begin : g_grp
    ssr_word_t rise, fall, hits;
    assign rise = raw_in[g] & ~cond_q[g] & ptr_q[g];
    assign fall = ~raw_in[g] & cond_q[g] & ntr_q[g];
    assign hits = rise | fall;
    assign new_evt[g] = |hits;

    always_comb begin
      cond_d[g] = raw_in[g];
      // set wins over the clear of a read
      evt_d[g] = (rd_evt[g] ? 15'h0000 : evt_q[g]) | hits;
      en_d[g] = en_q[g];
      ptr_d[g] = ptr_q[g];
      ntr_d[g] = ntr_q[g];
      if (preset_cmd) begin
        ptr_d[g] = `SSR_PTR_PRESET;
        ntr_d[g] = `SSR_NTR_PRESET;
        en_d[g] = `SSR_EN_PRESET;
      end else begin
        if (wr_en_sel[g]) begin
          en_d[g] = wval;
        end
        if (wr_ptr_sel[g]) begin
          ptr_d[g] = wval;
        end
        if (wr_ntr_sel[g]) begin
          ntr_d[g] = wval;
        end
      end
      sum_d[g] = |(evt_q[g] & en_q[g]);
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        cond_q[g] <= `SSR_COND_RESET;
        evt_q[g] <= `SSR_EVT_RESET;
        en_q[g] <= `SSR_EN_RESET;
        ptr_q[g] <= `SSR_PTR_RESET;
        ntr_q[g] <= `SSR_NTR_RESET;
        sum_q[g] <= 1'b0;
      end else begin
        cond_q[g] <= cond_d[g];
        evt_q[g] <= evt_d[g];
        en_q[g] <= en_d[g];
        ptr_q[g] <= ptr_d[g];
        ntr_q[g] <= ntr_d[g];
        sum_q[g] <= sum_d[g];
      end
    end
  end

  // ----------------------------------------
  // service request and interrupt
  // ----------------------------------------
  logic [`SSR_IRQ_W-1:0] ev_in;
  always_comb begin
    srq_d = |sum_q;
    ev_in = '0;
    ev_in[`SSR_IRQ_OPER_BIT] = new_evt[0];
    ev_in[`SSR_IRQ_QUES_BIT] = new_evt[1];
    ev_in[`SSR_IRQ_ERR_BIT] = errq.push;
    ev_in[`SSR_IRQ_OVF_BIT] = errq.push && errq.full && !errq.pop;
    ist_d = ist_q;
    imask_d = imask_q;
    if (wr_istat) begin
      ist_d = ist_q & ~pwdata[`SSR_IRQ_W-1:0];
    end
    ist_d = ist_d | ev_in;
    if (wr_imask) begin
      imask_d = pwdata[`SSR_IRQ_W-1:0];
    end
    irq_d = |(ist_d & imask_d);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      srq_q <= 1'b0;
      ist_q <= '0;
      imask_q <= '0;
      irq_q <= 1'b0;
    end else begin
      srq_q <= srq_d;
      ist_q <= ist_d;
      imask_q <= imask_d;
      irq_q <= irq_d;
    end
  end

  // ----------------------------------------
  // apb response
  // ----------------------------------------
  // read data held between reads, so a late sampler still sees the last word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign oper_summary = sum_q[0];
  assign ques_summary = sum_q[1];
  assign srq = srq_q;
  assign irq = irq_q;
endmodule : ssr_status_regs

/* File: testbench/ssr_status_regs_assertions.sv */
// port checker of the status reporting block
`timescale 1ns/1ns
`include "ssr_map.svh"
module ssr_status_regs_chk (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // status
  input wire logic [14:0] oper_cond_in,
  input wire logic oper_summary,
  input wire logic ques_summary,
  input wire logic srq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic acc = psel && penable && pready;
  property p_wait;
    psel && penable && !pready |=> pready;
  endproperty
  a_wait: assert property (p_wait) else $error("access not answered after one wait state");
  property p_pulse;
    pready |=> !pready;
  endproperty
  a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
  property p_cause;
    pready |-> psel && penable;
  endproperty
  a_cause: assert property (p_cause) else $error("pready without access phase");
  property p_err;
    acc |-> pslverr == ((paddr > `SSR_OFF_ERR_PUSH) || (paddr[1:0] != 2'b00));
  endproperty
  a_err: assert property (p_err) else $error("pslverr does not match address map");
  property p_width;
    acc && !pwrite && paddr < `SSR_OFF_PRESET |-> prdata[31:15] == 17'h00000;
  endproperty
  a_width: assert property (p_width) else $error("status part wider than fifteen bits");
  property p_cond;
    acc && !pwrite && paddr == `SSR_OFF_OPER_COND && oper_cond_in == $past(oper_cond_in)
      && oper_cond_in == $past(oper_cond_in, 2) |-> prdata[14:0] == oper_cond_in;
  endproperty
  a_cond: assert property (p_cond) else $error("condition read differs from live state");
  property p_srq;
    1'b1 |=> srq == $past(oper_summary || ques_summary);
  endproperty
  a_srq: assert property (p_srq) else $error("service request not following summaries");
  property p_preset;
    acc && pwrite && paddr == `SSR_OFF_PRESET |=> !oper_summary && !ques_summary;
  endproperty
  a_preset: assert property (p_preset) else $error("summary high after preset");
endmodule : ssr_status_regs_chk

bind ssr_status_regs ssr_status_regs_chk i_ssr_status_regs_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .oper_cond_in(oper_cond_in), .oper_summary(oper_summary), .ques_summary(ques_summary), .srq(srq));

/* File: testbench/tb_top.sv */
// self-checking bench of the status reporting block
`timescale 1ns/1ns
`include "ssr_map.svh"
module tb_top import ssr_pkg::*;;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic err_push = 1'b0, inst_reset = 1'b0, pready, pslverr, oper_summary, ques_summary, srq, irq, err_q;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic [15:0] err_code = 16'h0;
  ssr_word_t oper_cond_in = 15'h0, ques_cond_in = 15'h0;
  int n_fail = 0, total_checks = 0;
  always #25 pclk = ~pclk;
  ssr_status_regs i_ssr_status_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .oper_cond_in(oper_cond_in), .ques_cond_in(ques_cond_in), .err_push(err_push), .err_code(err_code),
    .inst_reset(inst_reset), .oper_summary(oper_summary), .ques_summary(ques_summary), .srq(srq), .irq(irq));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one apb transfer; registered outputs are read before the edge's own updates land
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_fail++;
      end_sim();
    end
    rdat = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rdat, e);
  endtask : rc
  task automatic cond(input ssr_word_t o, input ssr_word_t q);
    @(posedge pclk);
    oper_cond_in <= o;
    ques_cond_in <= q;
    repeat (3) @(posedge pclk);
  endtask : cond
  task automatic push(input logic [15:0] c);
    @(posedge pclk);
    err_code <= c;
    err_push <= 1'b1;
    @(posedge pclk);
    err_push <= 1'b0;
  endtask : push
  task automatic t_reset;
    rc("oper ptr", `SSR_OFF_OPER_PTR, 32'h00007fff);
    rc("ques ntr", `SSR_OFF_QUES_NTR, 32'h0);
    rc("unmapped", 12'h040, 32'h0);
    chk("slverr", {31'h0, err_q}, 32'h1);
  endtask : t_reset
  task automatic t_edges;
    cond(15'h0001, 15'h0010);
    rc("oper evt rise", `SSR_OFF_OPER_EVT, 32'h1);
    rc("oper evt cleared", `SSR_OFF_OPER_EVT, 32'h0);
    rc("ques evt rise", `SSR_OFF_QUES_EVT, 32'h10);
    rc("oper cond", `SSR_OFF_OPER_COND, 32'h1);
    rc("oper cond again", `SSR_OFF_OPER_COND, 32'h1);
    wr(`SSR_OFF_OPER_NTR, 32'h1);
    wr(`SSR_OFF_OPER_PTR, 32'h0);
    cond(15'h0, 15'h0);
    rc("oper evt fall", `SSR_OFF_OPER_EVT, 32'h1);
    rc("ques evt no fall", `SSR_OFF_QUES_EVT, 32'h0);
    wr(`SSR_OFF_QUES_NTR, 32'h10);
    wr(`SSR_OFF_QUES_PTR, 32'h0);
    cond(15'h0, 15'h0010);
    rc("ques evt ptr off", `SSR_OFF_QUES_EVT, 32'h0);
    cond(15'h0, 15'h0);
    rc("ques evt fall", `SSR_OFF_QUES_EVT, 32'h10);
  endtask : t_edges
  task automatic t_summary;
    wr(`SSR_OFF_OPER_EN, 32'h2);
    wr(`SSR_OFF_OPER_PTR, 32'h1);
    cond(15'h0001, 15'h0);
    chk("masked summary", {31'h0, oper_summary}, 32'h0);
    wr(`SSR_OFF_OPER_EN, 32'h1);
    repeat (3) @(posedge pclk);
    chk("oper summary", {31'h0, oper_summary}, 32'h1);
    chk("srq", {31'h0, srq}, 32'h1);
    chk("irq masked", {31'h0, irq}, 32'h0);
    wr(`SSR_OFF_IRQ_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq", {31'h0, irq}, 32'h1);
    wr(`SSR_OFF_IRQ_STAT, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    rc("oper evt", `SSR_OFF_OPER_EVT, 32'h1);
    repeat (3) @(posedge pclk);
    chk("summary gone", {30'h0, oper_summary, srq}, 32'h0);
  endtask : t_summary
  task automatic t_preset;
    wr(`SSR_OFF_QUES_EN, 32'hffffffff);
    rc("ques en width", `SSR_OFF_QUES_EN, 32'h00007fff);
    wr(`SSR_OFF_OPER_NTR, 32'h7fff);
    @(posedge pclk);
    inst_reset <= 1'b1;
    @(posedge pclk);
    inst_reset <= 1'b0;
    rc("ques en kept", `SSR_OFF_QUES_EN, 32'h00007fff);
    wr(`SSR_OFF_PRESET, 32'h0);
    rc("oper ptr", `SSR_OFF_OPER_PTR, 32'h00007fff);
    rc("ques ptr", `SSR_OFF_QUES_PTR, 32'h00007fff);
    rc("oper ntr", `SSR_OFF_OPER_NTR, 32'h0);
    rc("ques ntr", `SSR_OFF_QUES_NTR, 32'h0);
    rc("oper en", `SSR_OFF_OPER_EN, 32'h0);
    rc("ques en", `SSR_OFF_QUES_EN, 32'h0);
    wr(`SSR_OFF_QUES_EN, 32'h4);
    cond(15'h0001, 15'h0004);
    chk("ques summary", {31'h0, ques_summary}, 32'h1);
    rc("ques evt new", `SSR_OFF_QUES_EVT, 32'h4);
  endtask : t_preset
  task automatic t_race;
    fork
      apb(1'b0, `SSR_OFF_OPER_EVT, 32'h0);
      begin
        repeat (2) @(posedge pclk);
        oper_cond_in <= 15'h0003;
      end
    join
    chk("oper evt before race", rdat, 32'h0);
    rc("oper evt race kept", `SSR_OFF_OPER_EVT, 32'h2);
  endtask : t_race
  task automatic t_queue;
    rc("err empty", `SSR_OFF_ERR_NEXT, 32'h0);
    push(16'h0005);
    push(16'hfffd);
    rc("err count", `SSR_OFF_ERR_COUNT, 32'h2);
    rc("err oldest", `SSR_OFF_ERR_NEXT, 32'h5);
    rc("err negative", `SSR_OFF_ERR_NEXT, 32'hfffffffd);
    rc("err drained", `SSR_OFF_ERR_NEXT, 32'h0);
    chk("irq err masked", {31'h0, irq}, 32'h0);
  endtask : t_queue
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_edges();
    t_summary();
    t_preset();
    t_queue();
    t_race();
    end_sim();
  end
endmodule : tb_top
